/* File: design/aos_pkg.sv */
package aos_pkg;
  // Word and frame geometry
  localparam int AOS_WORD_W = 12;
  localparam int AOS_PAIRS = 6;
  localparam int AOS_FRAME_STEPS = 8;
  localparam int AOS_STEP_W = 3;
  // Stabilizer lock length in encode cycles
  localparam int AOS_LOCK_EDGES = 100;
  // Time base of the system clock
  localparam int AOS_SYS_CLK_HZ = 20_000_000;
  // Reset values of the configuration
  localparam logic [1:0] AOS_MODE_RST = 2'h0;
  localparam logic [1:0] AOS_PHASE_RST = 2'h0;
  localparam logic [2:0] AOS_DRIVE_RST = 3'h4;
  // Field positions inside the packed configuration word
  localparam int AOS_CFG_MODE_POS = 9;
  localparam int AOS_CFG_DCS_POS = 4;

  // Output formats
  typedef enum logic [1:0] {
    AOS_FULL_CMOS = 2'h0,
    AOS_DDR_CMOS = 2'h1,
    AOS_DDR_LVDS = 2'h2
  } aos_mode_t;

  // Drive current codes for the differential format
  typedef enum logic [2:0] {
    AOS_I_1P75 = 3'h0,
    AOS_I_2P1 = 3'h1,
    AOS_I_2P5 = 3'h2,
    AOS_I_3P0 = 3'h3,
    AOS_I_3P5 = 3'h4,
    AOS_I_4P0 = 3'h5,
    AOS_I_4P5 = 3'h6
  } aos_drive_t;

  // Settings as written through the configuration ports
  typedef struct packed {
    aos_mode_t mode;
    logic [1:0] phase;
    logic clk_inv;
    logic dcs_ser;
    aos_drive_t drive;
    logic term_en;
  } aos_cfg_t;

  // One conversion result with its range flag
  typedef struct packed {
    logic flag;
    logic [AOS_WORD_W-1:0] data;
  } aos_word_t;

  // Reset value of the configuration
  localparam aos_cfg_t AOS_CFG_RST = '{
    mode: AOS_FULL_CMOS, phase: AOS_PHASE_RST, clk_inv: 1'b0,
    dcs_ser: 1'b0, drive: AOS_I_3P5, term_en: 1'b0};
endpackage : aos_pkg

/* File: design/aos_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for levels entering a clock domain
module aos_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage is read by the second stage only
  logic [W-1:0] meta_reg;

  initial begin
    if (W < 1) $error("aos_sync: width must be positive");
  end

  // Both stages reset synchronously to zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : aos_sync
`default_nettype wire

/* File: design/aos_port.sv */
// Overview of operation
// - Output word is 12 bits, bit 11 MSB
// - Full rate: data changes on forwarded clock fall
// - Complement clock always inverse of true clock
// - Range flag high for over or under range
// - DDR carries two bits per line
// - DDR even bits clock low, odd high
// - DDR data changes on both clock edges
// - Forwarded clock phase delay is programmable with the stabilizer on
// - LVDS drive current and termination selectable
// - Stabilizer gives 50% internal clock
// - Stabilizer needs 100 encode cycles lock
// - Stabilizer enable from option reg or select
// - Complement encode grounded selects single-ended
// - Features set through control settings
// - Parallel mode: select low disables stabilizer
// - Range flag shares data pipeline latency
// - Conversion starts on true encode rise
`timescale 1ns/1ns
`default_nettype none
module aos_port
  import aos_pkg::*;
#(
  parameter int PIPE_LAT = 5,
  parameter int STOP_CYC = 64,
  parameter int SE_DET_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_link,
  input wire aos_cfg_t cfg_in,
  input wire logic par_mode,
  input wire logic cs_level,
  output aos_cfg_t cfg_applied,
  output logic dcs_locked_sys,
  input wire logic sample_clk_true,
  input wire logic sample_clk_comp,
  input wire aos_word_t core_word,
  output logic [AOS_WORD_W-1:0] sample_bits,
  output logic range_flag_true,
  output logic range_flag_comp,
  output logic fwd_clk_true,
  output logic fwd_clk_comp,
  output aos_drive_t drive_sel,
  output logic term_sel,
  output logic se_encode,
  output logic dcs_active,
  output logic dcs_locked,
  output logic conv_start
);
  // Elaboration check of parameter ranges
  initial begin
    if (PIPE_LAT < 1 || PIPE_LAT > 16) $error("aos_port: PIPE_LAT out of range");
    if (STOP_CYC <= AOS_FRAME_STEPS || STOP_CYC > 255) $error("aos_port: bad STOP_CYC");
    if (SE_DET_CYC < 2 || SE_DET_CYC > 255) $error("aos_port: bad SE_DET_CYC");
  end

  // Shifts a frame step back by the programmed phase
  function automatic logic [AOS_STEP_W-1:0] step_sub(input logic [AOS_STEP_W-1:0] a,
                                                     input logic [1:0] b);
    step_sub = a - {1'b0, b};
  endfunction : step_sub

  // System domain: configuration launch and lock status
  aos_cfg_t cfg_reg; // Last configuration launched across
  logic req_tgl_reg; // Toggles once per new configuration
  logic ack_sys; // Synchronised acknowledge toggle
  logic lock_lnk_reg; // Lock status, link side

  // Launch a changed configuration only once the previous one is taken,
  // so the bus is held stable while the link side samples it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_reg <= AOS_CFG_RST;
      req_tgl_reg <= 1'b0;
    end else if ((ack_sys == req_tgl_reg) && (cfg_in != cfg_reg)) begin
      cfg_reg <= cfg_in;
      req_tgl_reg <= ~req_tgl_reg;
    end
  end
  assign cfg_applied = cfg_reg;

  // Lock status returns through two flops
  aos_sync #(.W(1)) u_lock_sync (
    .clk(clk_sys), .nrst(nrst), .d(lock_lnk_reg), .q(dcs_locked_sys));

  // Link domain: reset is re-timed here, so its release meets clk_link cleanly
  logic nrst_lnk; // Reset as seen by the link logic
  aos_sync #(.W(1)) u_rst_sync (
    .clk(clk_link), .nrst(1'b1), .d(nrst), .q(nrst_lnk));
  logic req_lnk; // Request toggle seen in link domain
  logic ack_reg; // Acknowledge toggle
  aos_cfg_t cfg_lnk_reg; // Configuration held in link domain
  logic [3:0] pin_s; // Synchronised pins and straps
  logic enc_t_s, enc_c_s, par_s, cs_s;

  aos_sync #(.W(1)) u_ack_sync (
    .clk(clk_sys), .nrst(nrst), .d(ack_reg), .q(ack_sys));
  aos_sync #(.W(1)) u_req_sync (
    .clk(clk_link), .nrst(nrst_lnk), .d(req_tgl_reg), .q(req_lnk));
  aos_sync #(.W(4)) u_pin_sync (
    .clk(clk_link), .nrst(nrst_lnk),
    .d({sample_clk_true, sample_clk_comp, par_mode, cs_level}), .q(pin_s));
  assign {enc_t_s, enc_c_s, par_s, cs_s} = pin_s;

  // Capture configuration when a new request toggle arrives
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      cfg_lnk_reg <= AOS_CFG_RST;
      ack_reg <= 1'b0;
    end else if (req_lnk != ack_reg) begin
      cfg_lnk_reg <= cfg_reg;
      ack_reg <= req_lnk;
    end
  end

  // Single-ended encode detection: complement held low long enough
  logic [7:0] low_cnt_reg;
  logic se_reg;
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      low_cnt_reg <= '0;
      se_reg <= 1'b0;
    end else if (enc_c_s) begin
      low_cnt_reg <= '0; // Any high level means differential drive
      se_reg <= 1'b0;
    end else if (low_cnt_reg == 8'(SE_DET_CYC - 1)) begin
      se_reg <= 1'b1;
    end else begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end

  // Conversion start on the rise of true, or true high with comp low
  logic enc_lvl, enc_lvl_d_reg, start;
  assign enc_lvl = se_reg ? enc_t_s : (enc_t_s & ~enc_c_s);
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) enc_lvl_d_reg <= 1'b1; // Idle high: no false rise just after reset
    else enc_lvl_d_reg <= enc_lvl;
  end
  assign start = enc_lvl & ~enc_lvl_d_reg;

  // Stabilizer enable from the option bit or the select level
  logic dcs_en;
  assign dcs_en = par_s ? cs_s : cfg_lnk_reg.dcs_ser;

  // Period watch: a changed or vanished encode restarts the lock count
  logic [7:0] per_cnt_reg, per_last_reg;
  logic [6:0] lock_cnt_reg;
  logic per_bad;
  assign per_bad = (per_cnt_reg != per_last_reg) && (per_cnt_reg + 8'h01 != per_last_reg)
                   && (per_cnt_reg != per_last_reg + 8'h01);
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      per_cnt_reg <= '0;
      per_last_reg <= '0;
      lock_cnt_reg <= '0;
    end else if (!dcs_en) begin
      per_cnt_reg <= '0;
      lock_cnt_reg <= '0;
    end else if (start) begin
      per_cnt_reg <= '0;
      per_last_reg <= per_cnt_reg;
      if (per_bad) lock_cnt_reg <= '0;
      else if (lock_cnt_reg != 7'(AOS_LOCK_EDGES)) lock_cnt_reg <= lock_cnt_reg + 7'h01;
    end else if (per_cnt_reg == 8'(STOP_CYC)) begin
      lock_cnt_reg <= '0; // Encode stopped
    end else begin
      per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) lock_lnk_reg <= 1'b0;
    else lock_lnk_reg <= dcs_en && (lock_cnt_reg == 7'(AOS_LOCK_EDGES));
  end

  // Pipeline of words; the flag rides with its data
  aos_word_t pipe_reg [PIPE_LAT];
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      for (int i = 0; i < PIPE_LAT; i++) pipe_reg[i] <= '0;
    end else if (start) begin
      pipe_reg[0] <= core_word;
      for (int i = 1; i < PIPE_LAT; i++) pipe_reg[i] <= pipe_reg[i-1];
    end
  end

  // Frame step counter: 8 steps, 45 degrees each, restarted by each conversion.
  // It needs a link clock at eight times the encode rate; slower encode
  // simply holds the last step until the next start.
  logic [AOS_STEP_W-1:0] ph_reg;
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) ph_reg <= '0;
    else if (start) ph_reg <= '0;
    else if (ph_reg != AOS_STEP_W'(AOS_FRAME_STEPS - 1)) ph_reg <= ph_reg + 1'b1;
  end

  // Current word and format, swapped only at the word boundary
  aos_word_t cur_reg;
  aos_mode_t act_mode_reg;
  logic [1:0] act_phase_reg;
  logic act_inv_reg;
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      cur_reg <= '0;
      act_mode_reg <= AOS_FULL_CMOS;
      act_phase_reg <= AOS_PHASE_RST;
      act_inv_reg <= 1'b0;
    end else if (start) begin
      cur_reg <= pipe_reg[PIPE_LAT-1];
      act_mode_reg <= cfg_lnk_reg.mode;
      act_phase_reg <= dcs_en ? cfg_lnk_reg.phase : 2'h0; // Shift needs the stabilizer
      act_inv_reg <= cfg_lnk_reg.clk_inv;
    end
  end

  // Clock high half of the frame; with the stabilizer it is exactly
  // four of eight steps whatever the encode duty, otherwise it follows the pin
  logic hi_half, fwd_base;
  assign hi_half = start ? 1'b0
                 : dcs_en ? (ph_reg >= AOS_STEP_W'(AOS_FRAME_STEPS / 2) - 1'b1)
                 : ~enc_lvl; // without the stabilizer the halves follow the pin
  assign fwd_base = dcs_en ? (step_sub(start ? '0 : ph_reg + 1'b1, act_phase_reg)
                              >= AOS_STEP_W'(AOS_FRAME_STEPS / 2))
                           : ~enc_lvl;

  // Data lanes selected by format
  aos_word_t nxt_word;
  logic [AOS_WORD_W-1:0] dout_next;
  assign nxt_word = start ? pipe_reg[PIPE_LAT-1] : cur_reg;
  always_comb begin
    dout_next = '0;
    case (start ? cfg_lnk_reg.mode : act_mode_reg)
      AOS_FULL_CMOS: dout_next = nxt_word.data;
      AOS_DDR_CMOS: begin
        for (int k = 0; k < AOS_PAIRS; k++) begin
          dout_next[2*k+1] = hi_half ? nxt_word.data[2*k+1] : nxt_word.data[2*k];
          dout_next[2*k] = 1'b0;
        end
      end
      AOS_DDR_LVDS: begin
        for (int k = 0; k < AOS_PAIRS; k++) begin
          dout_next[2*k+1] = hi_half ? nxt_word.data[2*k+1] : nxt_word.data[2*k];
          dout_next[2*k] = ~dout_next[2*k+1];
        end
      end
      default: dout_next = '0;
    endcase
  end

  // Output flops
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      sample_bits <= '0;
      range_flag_true <= 1'b0;
      range_flag_comp <= 1'b0;
      fwd_clk_true <= 1'b0;
      fwd_clk_comp <= 1'b1;
    end else begin
      sample_bits <= dout_next;
      range_flag_true <= nxt_word.flag;
      range_flag_comp <= ((start ? cfg_lnk_reg.mode : act_mode_reg) == AOS_DDR_LVDS)
                         ? ~nxt_word.flag : 1'b0;
      fwd_clk_true <= fwd_base ^ (start ? cfg_lnk_reg.clk_inv : act_inv_reg);
      fwd_clk_comp <= ~(fwd_base ^ (start ? cfg_lnk_reg.clk_inv : act_inv_reg));
    end
  end

  // Status and driver settings
  always_ff @(posedge clk_link) begin
    if (!nrst_lnk) begin
      drive_sel <= AOS_I_3P5;
      term_sel <= 1'b0;
      se_encode <= 1'b0;
      dcs_active <= 1'b0;
      dcs_locked <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      drive_sel <= cfg_lnk_reg.drive;
      term_sel <= cfg_lnk_reg.term_en && (act_mode_reg == AOS_DDR_LVDS);
      se_encode <= se_reg;
      dcs_active <= dcs_en;
      dcs_locked <= lock_lnk_reg;
      conv_start <= start;
    end
  end

  // Checks, held off until both domains are out of reset
  default clocking cb @(posedge clk_link); endclocking
  default disable iff (!nrst || !nrst_lnk);

  sequence s_word_edge;
    conv_start && $stable(act_mode_reg);
  endsequence

  property p_comp_clk;
    fwd_clk_comp == ~fwd_clk_true;
  endproperty
  a_comp_clk: assert property (p_comp_clk) else $error("clock pair not complementary");

  property p_full_fall;
    ($changed(sample_bits) && act_mode_reg == AOS_FULL_CMOS && dcs_active && !act_inv_reg
      && act_phase_reg == 2'h0 && $past(ph_reg) == 3'h7) |-> $fell(fwd_clk_true);
  endproperty
  a_full_fall: assert property (p_full_fall) else $error("data moved off clock fall");

  property p_ddr_unused;
    (act_mode_reg == AOS_DDR_CMOS && !start) |=> ((sample_bits & 12'h555) == 12'h000);
  endproperty
  a_ddr_unused: assert property (p_ddr_unused) else $error("unused line toggles");

  property p_ddr_even;
    (act_mode_reg == AOS_DDR_CMOS && dcs_en && !start && ph_reg == 3'h1)
      |=> sample_bits[11] == cur_reg.data[10];
  endproperty
  a_ddr_even: assert property (p_ddr_even) else $error("even bit not in low half");

  property p_ddr_odd;
    (act_mode_reg != AOS_FULL_CMOS && dcs_en && !start && ph_reg == 3'h5)
      |=> sample_bits[1] == cur_reg.data[1];
  endproperty
  a_ddr_odd: assert property (p_ddr_odd) else $error("odd bit not in high half");

  property p_flag_lat;
    start |=> range_flag_true == $past(pipe_reg[PIPE_LAT-1].flag);
  endproperty
  a_flag_lat: assert property (p_flag_lat) else $error("flag latency differs");

  property p_lock_len;
    dcs_locked |-> $past(lock_cnt_reg, 2) == 7'(AOS_LOCK_EDGES);
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("locked before 100 cycles");

  property p_par_cs;
    (par_s && !cs_s) |=> !dcs_active;
  endproperty
  a_par_cs: assert property (p_par_cs) else $error("stabilizer on with select low");

  property p_mode_bound;
    $changed(act_mode_reg) |-> $past(start);
  endproperty
  a_mode_bound: assert property (p_mode_bound) else $error("format changed mid word");

  property p_start_edge;
    s_word_edge |-> $past(enc_lvl) && !$past(enc_lvl_d_reg);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start without encode rise");
endmodule : aos_port
`default_nettype wire

/* File: test/aos_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Receiver model: rebuilds words at forwarded clock edges and checks the pins
module aos_rx_model
  import aos_pkg::*;
(
  input wire logic clk_link,
  input wire logic clr,
  input wire aos_mode_t mode,
  input wire logic [AOS_WORD_W-1:0] sample_bits,
  input wire logic range_flag_true,
  input wire logic range_flag_comp,
  input wire logic fwd_clk_true,
  input wire logic fwd_clk_comp,
  output logic [15:0] n_words,
  output logic [15:0] n_err
);
  logic [AOS_WORD_W-1:0] bits_q; // Bits seen in the closing half
  logic [AOS_WORD_W-1:0] half_q; // Word being assembled
  logic [AOS_WORD_W-1:0] last_q; // Last complete word
  logic clk_q;
  logic flag_q;
  logic have_q;
  initial begin
    {bits_q, half_q, last_q, clk_q, flag_q, have_q, n_words, n_err} = '0;
  end
  // Falling link edge: outputs are settled, so no race with their launch
  always @(negedge clk_link) begin : cap
    logic [AOS_WORD_W-1:0] w;
    logic done;
    w = half_q;
    done = 1'b0;
    if (fwd_clk_comp !== ~fwd_clk_true) n_err++;
    if (range_flag_comp !== (mode == AOS_DDR_LVDS ? ~range_flag_true : 1'b0)) n_err++;
    // Spare lines: low in DDR CMOS, complement of the lane in LVDS
    for (int k = 0; k < AOS_PAIRS; k++) begin
      if (mode != AOS_FULL_CMOS && sample_bits[2*k] !==
          (mode == AOS_DDR_LVDS ? ~sample_bits[2*k+1] : 1'b0)) n_err++;
    end
    // Rising forwarded clock: full word, or the even half in DDR
    if (!clk_q && fwd_clk_true) begin
      if (mode == AOS_FULL_CMOS) begin
        w = bits_q;
        done = 1'b1;
      end else begin
        for (int k = 0; k < AOS_PAIRS; k++) w[2*k] = bits_q[2*k+1];
      end
    end
    // Falling forwarded clock closes the odd half in DDR
    if (clk_q && !fwd_clk_true && mode != AOS_FULL_CMOS) begin
      for (int k = 0; k < AOS_PAIRS; k++) w[2*k+1] = bits_q[2*k+1];
      done = 1'b1;
    end
    if (done) begin
      if (flag_q !== ^w) n_err++;
      if (have_q && w !== last_q + 12'h001) n_err++;
      last_q = w;
      have_q = 1'b1;
      n_words++;
    end
    bits_q = sample_bits;
    flag_q = range_flag_true;
    clk_q = fwd_clk_true;
    half_q = w;
    // Words around a format change or lock are not trusted
    if (clr) begin
      n_words = '0;
      n_err = '0;
      have_q = 1'b0;
    end
  end
endmodule : aos_rx_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import aos_pkg::*;
;
  typedef struct {aos_mode_t mode; aos_drive_t drive; logic term;} aos_tb_row_t;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic nrst = 1'b0;
  logic par_mode = 1'b0;
  logic cs_level = 1'b0;
  logic enc_t = 1'b0;
  logic enc_c = 1'b1;
  logic se_mode = 1'b0; // Hold the complement encode pin at ground
  logic enc_run = 1'b1; // Encode clock running
  logic rx_clr = 1'b0;
  aos_cfg_t cfg_in = AOS_CFG_RST;
  aos_word_t core_word = '{flag: 1'b0, data: 12'hFF0};
  aos_cfg_t cfg_applied;
  aos_drive_t drive_sel;
  logic [AOS_WORD_W-1:0] sample_bits;
  logic dcs_locked_sys, range_flag_true, range_flag_comp, fwd_clk_true, fwd_clk_comp;
  logic term_sel, se_encode, dcs_active, dcs_locked, conv_start;
  logic [15:0] n_words, n_err;
  int ecnt = 0;
  int n_start = 0;
  int n_fail = 0;
  int check_count = 0;
  // Ordinary cases: format with the driver settings they should show
  aos_tb_row_t rows[4] = '{'{AOS_FULL_CMOS, AOS_I_3P5, 1'b0},
    '{AOS_DDR_CMOS, AOS_I_1P75, 1'b1}, '{AOS_DDR_LVDS, AOS_I_4P5, 1'b1},
    '{AOS_DDR_LVDS, AOS_I_2P1, 1'b0}};

  always #25 clk_sys = ~clk_sys;
  // 12 ns link clock; its rising edges never meet the system clock rising edges
  always #6 clk_link = ~clk_link;

  // Encode source, 8 link cycles a period, 3/8 duty to lean on the stabilizer
  // About 10 Msps, above the lowest rate the stabilizer may be run at
  always @(posedge clk_link) begin
    ecnt <= (ecnt == 7) ? 0 : ecnt + 1;
    enc_t <= enc_run && ecnt < 3;
    enc_c <= se_mode ? 1'b0 : !(enc_run && ecnt < 3);
    n_start <= n_start + int'(conv_start);
    // Counting words with parity flag let the receiver check order and flag
    if (conv_start === 1'b1) begin
      core_word.data <= core_word.data + 12'h001;
      core_word.flag <= ^(core_word.data + 12'h001);
    end
  end

  aos_port DUT (.clk_sys(clk_sys), .nrst(nrst), .clk_link(clk_link), .cfg_in(cfg_in),
    .par_mode(par_mode), .cs_level(cs_level), .cfg_applied(cfg_applied),
    .dcs_locked_sys(dcs_locked_sys), .sample_clk_true(enc_t), .sample_clk_comp(enc_c),
    .core_word(core_word), .sample_bits(sample_bits), .range_flag_true(range_flag_true),
    .range_flag_comp(range_flag_comp), .fwd_clk_true(fwd_clk_true),
    .fwd_clk_comp(fwd_clk_comp), .drive_sel(drive_sel), .term_sel(term_sel),
    .se_encode(se_encode), .dcs_active(dcs_active), .dcs_locked(dcs_locked),
    .conv_start(conv_start));

  aos_rx_model u_rx (.clk_link(clk_link), .clr(rx_clr), .mode(cfg_in.mode),
    .sample_bits(sample_bits), .range_flag_true(range_flag_true),
    .range_flag_comp(range_flag_comp), .fwd_clk_true(fwd_clk_true),
    .fwd_clk_comp(fwd_clk_comp), .n_words(n_words), .n_err(n_err));

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic sys(int n);
    repeat (n) @(posedge clk_sys);
  endtask : sys

  // Lock must come about one hundred encode periods after the reference
  task automatic lock_after();
    int s0;
    s0 = n_start;
    for (int i = 0; i < 600 && dcs_locked !== 1'b1; i++) sys(1);
    chk("lock_periods", 1, (n_start - s0) inside {[98:104]});
    sys(4);
    chk("lock_sys", 1, dcs_locked_sys);
  endtask : lock_after

  // Forwarded clock rise, counted in link cycles from the word change
  task automatic phase_chk(logic [1:0] p, logic inv, int exp_d);
    int d;
    logic prev;
    sys(1);
    cfg_in.phase <= p;
    cfg_in.clk_inv <= inv;
    sys(20);
    @(posedge conv_start);
    @(negedge clk_link);
    d = 0;
    prev = fwd_clk_true;
    while (d < 12 && !(prev === 1'b0 && fwd_clk_true === 1'b1)) begin
      prev = fwd_clk_true;
      @(negedge clk_link);
      d++;
    end
    chk("fwd_rise_delay", 16'(exp_d), 16'(d));
  endtask : phase_chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    sys(16);
    nrst <= 1'b1;
    cfg_in.dcs_ser <= 1'b1;
    for (int i = 0; i < 100 && dcs_active !== 1'b1; i++) sys(1);
    lock_after();
    $display("test lock done");
    foreach (rows[i]) begin
      cfg_in.mode <= rows[i].mode;
      cfg_in.drive <= rows[i].drive;
      cfg_in.term_en <= rows[i].term;
      sys(40);
      rx_clr <= 1'b1;
      sys(1);
      rx_clr <= 1'b0;
      sys(40);
      chk("cfg_applied", 16'(cfg_in), 16'(cfg_applied));
      chk("rx_errors", 0, n_err);
      chk("rx_words", 1, n_words > 16'h0010);
      chk("drive_sel", 16'(rows[i].drive), 16'(drive_sel));
      if (rows[i].mode == AOS_DDR_LVDS) begin
        chk("term_sel", 16'(rows[i].term), 16'(term_sel));
      end else begin
        chk("term_off", 0, term_sel);
      end
      $display("test row %0d done", i);
    end
    // Clock phase steps of one link cycle, and inversion on top
    phase_chk(2'h0, 1'b0, 4);
    phase_chk(2'h2, 1'b0, 6);
    phase_chk(2'h1, 1'b1, 1);
    sys(1);
    cfg_in.phase <= AOS_PHASE_RST;
    cfg_in.clk_inv <= 1'b0;
    $display("test phase done");
    // Parallel strap: select level alone rules the stabilizer
    par_mode <= 1'b1;
    sys(10);
    chk("dcs_cs_low", 0, {dcs_active, dcs_locked});
    cs_level <= 1'b1;
    sys(10);
    chk("dcs_cs_high", 1, dcs_active);
    par_mode <= 1'b0;
    cfg_in.dcs_ser <= 1'b0;
    sys(10);
    chk("dcs_ser_off", 0, dcs_active);
    cfg_in.dcs_ser <= 1'b1;
    $display("test enable done");
    // Stopped encode loses lock; relock counted from the restart
    sys(10);
    enc_run <= 1'b0;
    sys(30);
    chk("lock_lost", 0, dcs_locked);
    enc_run <= 1'b1;
    lock_after();
    $display("test relock done");
    // Grounded complement selects single-ended encode; conversions go on
    se_mode <= 1'b1;
    sys(8);
    chk("se_encode_on", 1, se_encode);
    begin : se_conv
      int s0;
      s0 = n_start;
      sys(10);
      chk("se_conversions", 1, (n_start - s0) > 3);
    end
    se_mode <= 1'b0;
    sys(8);
    chk("se_encode_off", 0, se_encode);
    $display("test encode mode done");
    report_and_stop();
  end

  // Whole run needs about 46 us
  initial begin
    #200_000;
    n_fail++;
    $display("[FAIL] watchdog expected finish seen timeout");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
